// ### tb/pic_host_model.sv
// host software model: register bus master and list table transfers
// assumes the one-cycle strobe register port of the ingress control block
`timescale 1ns/1ps
`default_nettype none
module pic_host_model #(
  parameter int ACC_CYCLES = 4
) (
  input wire logic clk_sys,
  output logic [11:0] reg_addr,
  output logic [7:0] reg_wdata,
  output logic reg_wr,
  output logic reg_rd,
  input wire logic [7:0] reg_rdata
);
  // ==========================================
  // bus cycles
  initial begin
    reg_addr = 12'h000;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  end
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    reg_addr <= ~a;
    reg_wdata <= ~d;
    @(posedge clk_sys);
  endtask
  task automatic rd(input logic [11:0] a, output logic [7:0] d);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    reg_addr <= ~a;
    @(negedge clk_sys);
    d = reg_rdata;
    @(posedge clk_sys);
  endtask
  // ==========================================
  // list table transfer
  // global mirroring setup lies outside this block
  // priority select is written as one whole byte
  task automatic xfer(input logic dir, input logic [3:0] idx, input logic [15:0] be,
                      output logic first, output logic ok);
    logic [7:0] d;
    int n;
    wr(pic_pkg::ACL_CTRL_OFF, {3'h0, dir, idx});
    wr(pic_pkg::BE_MSB_OFF, be[15:8]);
    wr(pic_pkg::BE_LSB_OFF, be[7:0]);
    rd(pic_pkg::ACL_CTRL_OFF, d);
    first = dir ? d[6] : d[5];
    n = 0;
    while (((dir ? d[6] : d[5]) !== 1'b1) && n < ACC_CYCLES + 2) begin
      rd(pic_pkg::ACL_CTRL_OFF, d);
      n++;
    end
    ok = dir ? d[6] : d[5];
  endtask
endmodule
`default_nettype wire

// ### tb/port_ingress_ctrl_regs_test.sv
// testbench of the per-port ingress control registers
// assumes the host model drives the register port, packets come from here
`timescale 1ns/1ps
`default_nettype none
module port_ingress_ctrl_regs_test;
  // ==========================================
  // signals
  localparam int ACC = 4;
  logic clk_sys;
  logic reset;
  logic [11:0] reg_addr;
  logic [7:0] reg_wdata;
  logic reg_wr;
  logic reg_rd;
  logic [7:0] reg_rdata;
  logic rx_pkt_valid;
  pic_pkg::pic_cls_in_t rx_cls;
  logic tx_pkt_valid;
  pic_pkg::pic_rx_out_t rx_out;
  pic_pkg::pic_tx_out_t tx_out;
  logic sniff_tx_en;
  int errors;
  int checks_done;
  logic [7:0] d;
  logic f;
  logic ok;
  pic_pkg::pic_cls_in_t c;
  pic_pkg::pic_rx_out_t rxo;
  pic_pkg::pic_tx_out_t txo;
  logic [11:0] roff [4] = '{12'h800, 12'h801, 12'h802, 12'h612};
  logic [7:0] rexp [4] = '{8'h62, 8'hdf, 8'h07, 8'h7f};
  logic [7:0] mv [5] = '{8'h00, 8'h40, 8'h20, 8'h02, 8'h62};
  logic [7:0] sv [8] = '{8'h00, 8'h01, 8'h02, 8'h04, 8'h08, 8'h10, 8'h9f, 8'h5f};
  logic [7:0] pv [8] = '{8'h05, 8'h01, 8'h02, 8'h04, 8'h00, 8'h02, 8'h04, 8'h07};
  // ==========================================
  // instances
  pic_regs #(.ACC_CYCLES(ACC)) DUT (.clk_sys(clk_sys), .reset(reset), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .rx_pkt_valid(rx_pkt_valid), .rx_cls(rx_cls), .tx_pkt_valid(tx_pkt_valid),
    .rx_out(rx_out), .tx_out(tx_out), .sniff_tx_en(sniff_tx_en));
  pic_host_model #(.ACC_CYCLES(ACC)) host (.clk_sys(clk_sys), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
  // ==========================================
  // helpers
  always begin
    #2;
    clk_sys = ~clk_sys;
  end
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask
  task automatic complete_run;
    $display("checks %0d, errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic pkt(input pic_pkg::pic_cls_in_t cv);
    rx_pkt_valid <= 1'b1;
    tx_pkt_valid <= 1'b1;
    rx_cls <= cv;
    @(posedge clk_sys);
    rx_pkt_valid <= 1'b0;
    tx_pkt_valid <= 1'b0;
    rx_cls <= ~cv;
    @(negedge clk_sys);
    rxo = rx_out;
    txo = tx_out;
    @(posedge clk_sys);
  endtask
  initial begin
    repeat (5000) @(posedge clk_sys);
    errors++;
    complete_run();
  end
  // ==========================================
  // tests
  initial begin
    clk_sys = 1'b0;
    reset = 1'b1;
    rx_pkt_valid = 1'b0;
    tx_pkt_valid = 1'b0;
    rx_cls = '0;
    errors = 0;
    checks_done = 0;
    repeat (8) @(posedge clk_sys);
    reset <= 1'b0;
    host.rd(pic_pkg::ACL_CTRL_OFF, d);
    chk(d, 8'h60);
    host.rd(12'h7ff, d);
    chk(d, 8'h00);
    for (int i = 0; i < 4; i++) begin
      host.rd(roff[i], d);
      chk(d, (i == 3) ? 8'h60 : 8'h00);
      host.wr(roff[i], 8'hff);
      host.rd(roff[i], d);
      chk(d, rexp[i]);
    end
    for (int i = 0; i < 16; i++) host.wr(pic_pkg::ENTRY_BASE + 12'(i), 8'h10 + 8'(i));
    host.wr(pic_pkg::BE_MSB_OFF, 8'hff);
    host.rd(pic_pkg::ACL_CTRL_OFF, d);
    chk(d, 8'h7f);
    host.xfer(1'b1, 4'h3, 16'hffff, f, ok);
    chk({7'h0, f}, 8'h00);
    chk({7'h0, ok}, 8'h01);
    for (int i = 0; i < 16; i++) host.wr(pic_pkg::ENTRY_BASE + 12'(i), 8'h00);
    host.xfer(1'b0, 4'h3, 16'hf000, f, ok);
    chk({7'h0, f}, 8'h00);
    chk({7'h0, ok}, 8'h01);
    for (int i = 0; i < 16; i++) begin
      host.rd(pic_pkg::ENTRY_BASE + 12'(i), d);
      chk(d, (i < 4) ? 8'h10 + 8'(i) : 8'h00);
    end
    c = '0;
    host.wr(pic_pkg::DEFPRI_OFF, 8'h05);
    host.wr(pic_pkg::PRIO_OFF, 8'h00);
    for (int i = 0; i < 5; i++) begin
      host.wr(pic_pkg::MIRR_OFF, mv[i]);
      pkt(c);
      chk({5'h0, rxo.valid, rxo.fwd_normal, txo.fwd_normal}, 8'h07);
      chk({7'h0, rxo.monitored}, {7'h0, mv[i][6]});
      chk({6'h0, txo.valid, txo.monitored}, {6'h0, 1'b1, mv[i][5]});
      chk({7'h0, sniff_tx_en}, {7'h0, mv[i][1]});
    end
    c.hit = 5'h1f;
    c.prio = {3'h2, 3'h0, 3'h4, 3'h2, 3'h1};
    for (int i = 0; i < 8; i++) begin
      host.wr(pic_pkg::PRIO_OFF, sv[i]);
      pkt(c);
      chk({5'h0, rxo.prio}, pv[i]);
    end
    c.hit = 5'h00;
    host.wr(pic_pkg::PRIO_OFF, 8'h01);
    pkt(c);
    chk({5'h0, rxo.prio}, 8'h05);
    reset <= 1'b1;
    repeat (2) @(posedge clk_sys);
    reset <= 1'b0;
    host.rd(pic_pkg::MIRR_OFF, d);
    chk(d, 8'h00);
    host.rd(pic_pkg::ACL_CTRL_OFF, d);
    chk(d, 8'h60);
    complete_run();
  end
endmodule
`default_nettype wire

// ### verilog/pic_acl_engine.sv
// list table of 16 entries of 16 bytes with timed masked transfers
// assumes start only when not busy; window bytes are copied in at start
`timescale 1ns/1ps
`default_nettype none
module pic_acl_engine #(
  parameter int ACC_CYCLES = pic_pkg::ACC_CYCLES
) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic start,
  input wire logic dir,
  input wire logic [3:0] idx,
  input wire logic [15:0] be,
  input wire logic [15:0][7:0] wdat,
  output logic busy,
  output logic done,
  output logic done_dir,
  output logic [15:0] done_be,
  output logic [15:0][7:0] rd_bytes
);
  localparam int CNT_W = pic_pkg::CNT_W;
  pic_pkg::pic_eng_state_t st;
  pic_pkg::pic_eng_state_t nxt;
  // ==========================================
  // outputs
  assign busy = (st.st == pic_pkg::ENG_RUN);
  assign done = busy && (st.cnt == '0);
  assign done_dir = st.dir;
  assign done_be = st.be;
  assign rd_bytes = st.tbl[st.idx];
  // ==========================================
  // transfer sequence
  always_comb begin
    nxt = st;
    case (st.st)
      pic_pkg::ENG_IDLE: begin
        if (start) begin
          nxt.st = pic_pkg::ENG_RUN;
          nxt.cnt = CNT_W'(ACC_CYCLES - 1);
          nxt.dir = dir;
          nxt.idx = idx;
          nxt.be = be;
          nxt.wdat = wdat;
        end
      end
      pic_pkg::ENG_RUN: begin
        if (st.cnt == '0) begin
          nxt.st = pic_pkg::ENG_IDLE;
          for (int b = 0; b < 16; b++) begin
            if (st.dir && st.be[15-b]) begin
              nxt.tbl[st.idx][b] = st.wdat[b];
            end
          end
        end else begin
          nxt.cnt = st.cnt - 1'b1;
        end
      end
      default: nxt.st = pic_pkg::ENG_IDLE;
    endcase
    if (reset) begin
      nxt = '0;
    end
  end
  always_ff @(posedge clk_sys) begin
    st <= nxt;
  end
endmodule
`default_nettype wire

// ### verilog/pic_pkg.sv
// shared constants and types of the port ingress control registers
// assumes an 8-bit register port with 12-bit per-port offsets
package pic_pkg;
  // ==========================================
  // register offsets
  localparam logic [11:0] ENTRY_BASE = 12'h600;
  localparam logic [11:0] BE_MSB_OFF = 12'h610;
  localparam logic [11:0] BE_LSB_OFF = 12'h611;
  localparam logic [11:0] ACL_CTRL_OFF = 12'h612;
  localparam logic [11:0] MIRR_OFF = 12'h800;
  localparam logic [11:0] PRIO_OFF = 12'h801;
  localparam logic [11:0] DEFPRI_OFF = 12'h802;
  // ==========================================
  // field positions and writable masks
  localparam int CTRL_WR_DONE_BIT = 6;
  localparam int CTRL_RD_DONE_BIT = 5;
  localparam int CTRL_DIR_BIT = 4;
  localparam int MIRR_RX_BIT = 6;
  localparam int MIRR_TX_BIT = 5;
  localparam int MIRR_SNIF_BIT = 1;
  localparam int PRIO_HIGH_BIT = 7;
  localparam int PRIO_OR_BIT = 6;
  localparam logic [7:0] MIRR_MASK = 8'h62;
  localparam logic [7:0] PRIO_MASK = 8'hdf;
  // ==========================================
  // reset values and counts
  localparam logic DONE_RST = 1'b1;
  localparam logic [7:0] MIRR_RST = 8'h00;
  localparam logic [7:0] PRIO_RST = 8'h00;
  localparam logic [2:0] DEFPRI_RST = 3'h0;
  localparam int ACC_CYCLES = 4;
  localparam int CNT_W = 3;
  localparam int NUM_SRC = 5;
  // ==========================================
  // types
  typedef enum logic {ENG_IDLE = 1'b0, ENG_RUN = 1'b1} pic_eng_st_t;
  typedef struct packed {
    logic [4:0] hit;
    logic [4:0][2:0] prio;
  } pic_cls_in_t;
  typedef struct packed {
    logic valid;
    logic [2:0] prio;
    logic monitored;
    logic fwd_normal;
  } pic_rx_out_t;
  typedef struct packed {
    logic valid;
    logic monitored;
    logic fwd_normal;
  } pic_tx_out_t;
  typedef struct packed {
    logic [15:0][7:0] win;
    logic [7:0] be_msb;
    logic [7:0] be_lsb;
    logic dir;
    logic [3:0] idx;
    logic wr_done;
    logic rd_done;
    logic [7:0] mirr;
    logic [7:0] prio_sel;
    logic [2:0] defpri;
    logic [7:0] rd_data;
    pic_rx_out_t rx;
    pic_tx_out_t tx;
  } pic_state_t;
  typedef struct packed {
    pic_eng_st_t st;
    logic [CNT_W-1:0] cnt;
    logic dir;
    logic [3:0] idx;
    logic [15:0] be;
    logic [15:0][7:0] wdat;
    logic [15:0][15:0][7:0] tbl;
  } pic_eng_state_t;
endpackage

// ### verilog/pic_prio_class.sv
// combines the enabled ingress priority classifiers into one priority
// assumes classifier hits arrive with the packet, indexed as the select bits
`timescale 1ns/1ps
`default_nettype none
module pic_prio_class (
  input wire pic_pkg::pic_cls_in_t cls,
  input wire logic [7:0] sel,
  input wire logic [2:0] defpri,
  output logic [2:0] prio
);
  // ==========================================
  // enabled sources
  logic [pic_pkg::NUM_SRC-1:0] en_hit;
  logic [2:0] hi;
  logic [2:0] orv;
  logic [2:0] last;
  genvar g;
  generate
    for (g = 0; g < pic_pkg::NUM_SRC; g++) begin : g_en
      assign en_hit[g] = cls.hit[g] & sel[g];
    end
  endgenerate
  // ==========================================
  // combine
  always_comb begin
    hi = 3'h0;
    orv = 3'h0;
    last = 3'h0;
    for (int i = 0; i < pic_pkg::NUM_SRC; i++) begin
      if (en_hit[i]) begin
        if (cls.prio[i] > hi) begin
          hi = cls.prio[i];
        end
        orv = orv | cls.prio[i];
        last = cls.prio[i];
      end
    end
    if (en_hit == '0) begin
      prio = defpri;
    end else if (sel[pic_pkg::PRIO_HIGH_BIT]) begin
      prio = hi;
    end else if (sel[pic_pkg::PRIO_OR_BIT]) begin
      prio = orv;
    end else begin
      prio = last;
    end
  end
endmodule
`default_nettype wire

// ### verilog/pic_regs.sv
// per-port ingress control registers: list table access, mirroring,
// priority classification select
// assumes one-cycle read and write strobes, read data the cycle after
//
// How it works
// - write flag clears, sets when write completes
// - read flag low until results loaded
// - only enabled entry bytes take part
// - receive sniff marks received packets monitored
// - transmit sniff marks sent packets monitored
// - sniffer bit makes port mirror destination
// - bit 7 picks highest priority
// - bit 6 ORs available priorities
// - bit 4 enables MAC classification
// - bit 3 enables VLAN classification
// - bit 2 enables tag priority classification
// - bit 1 enables Diffserv classification
// - bit 0 enables list-rule classification
// - no hit gives port default priority
`timescale 1ns/1ps
`default_nettype none
module pic_regs #(
  parameter int ACC_CYCLES = pic_pkg::ACC_CYCLES
) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic [11:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic rx_pkt_valid,
  input wire pic_pkg::pic_cls_in_t rx_cls,
  input wire logic tx_pkt_valid,
  output pic_pkg::pic_rx_out_t rx_out,
  output pic_pkg::pic_tx_out_t tx_out,
  output logic sniff_tx_en
);
  pic_pkg::pic_state_t st;
  pic_pkg::pic_state_t nxt;
  logic eng_start;
  logic eng_busy;
  logic eng_done;
  logic eng_dir;
  logic [15:0] eng_be;
  logic [15:0][7:0] eng_rd;
  logic [2:0] cls_prio;

  // ==========================================
  // decode helpers
  function automatic logic is_entry(input logic [11:0] a);
    is_entry = (a[11:4] == pic_pkg::ENTRY_BASE[11:4]);
  endfunction

  function automatic logic [7:0] rd_mux(input logic [11:0] a,
                                        input pic_pkg::pic_state_t s);
    logic [7:0] v;
    v = 8'h00;
    case (a)
      pic_pkg::BE_MSB_OFF: v = s.be_msb;
      pic_pkg::BE_LSB_OFF: v = s.be_lsb;
      pic_pkg::ACL_CTRL_OFF: v = {1'b0, s.wr_done, s.rd_done, s.dir, s.idx};
      pic_pkg::MIRR_OFF: v = s.mirr;
      pic_pkg::PRIO_OFF: v = s.prio_sel;
      pic_pkg::DEFPRI_OFF: v = {5'h00, s.defpri};
      default: begin
        if (is_entry(a)) begin
          v = s.win[a[3:0]];
        end
      end
    endcase
    rd_mux = v;
  endfunction

  // ==========================================
  // list table engine
  pic_acl_engine #(
    .ACC_CYCLES(ACC_CYCLES)
  ) u_engine (
    .clk_sys(clk_sys),
    .reset(reset),
    .start(eng_start),
    .dir(st.dir),
    .idx(st.idx),
    .be({st.be_msb, reg_wdata}),
    .wdat(st.win),
    .busy(eng_busy),
    .done(eng_done),
    .done_dir(eng_dir),
    .done_be(eng_be),
    .rd_bytes(eng_rd)
  );

  // ==========================================
  // priority classification
  pic_prio_class u_class (
    .cls(rx_cls),
    .sel(st.prio_sel),
    .defpri(st.defpri),
    .prio(cls_prio)
  );

  // ==========================================
  // next state
  always_comb begin
    nxt = st;
    eng_start = 1'b0;
    nxt.rd_data = 8'h00;
    if (reg_wr) begin
      case (reg_addr)
        pic_pkg::BE_MSB_OFF: nxt.be_msb = reg_wdata;
        pic_pkg::BE_LSB_OFF: begin
          nxt.be_lsb = reg_wdata;
          eng_start = !eng_busy;
        end
        pic_pkg::ACL_CTRL_OFF: begin
          nxt.dir = reg_wdata[pic_pkg::CTRL_DIR_BIT];
          nxt.idx = reg_wdata[3:0];
        end
        pic_pkg::MIRR_OFF: nxt.mirr = reg_wdata & pic_pkg::MIRR_MASK;
        pic_pkg::PRIO_OFF: nxt.prio_sel = reg_wdata & pic_pkg::PRIO_MASK;
        pic_pkg::DEFPRI_OFF: nxt.defpri = reg_wdata[2:0];
        default: begin
          if (is_entry(reg_addr)) begin
            nxt.win[reg_addr[3:0]] = reg_wdata;
          end
        end
      endcase
    end
    // completion flag of the started direction drops at start
    if (eng_start) begin
      if (st.dir) begin
        nxt.wr_done = 1'b0;
      end else begin
        nxt.rd_done = 1'b0;
      end
    end
    // completion flags rise when done
    if (eng_done) begin
      if (eng_dir) begin
        nxt.wr_done = 1'b1;
      end else begin
        nxt.rd_done = 1'b1;
        for (int b = 0; b < 16; b++) begin
          if (eng_be[15-b]) begin
            nxt.win[b] = eng_rd[b];
          end
        end
      end
    end
    if (reg_rd) begin
      nxt.rd_data = rd_mux(reg_addr, st);
    end
    // packet side
    nxt.rx.valid = rx_pkt_valid;
    nxt.rx.prio = rx_pkt_valid ? cls_prio : 3'h0;
    nxt.rx.monitored = rx_pkt_valid & st.mirr[pic_pkg::MIRR_RX_BIT];
    nxt.rx.fwd_normal = rx_pkt_valid;
    nxt.tx.valid = tx_pkt_valid;
    nxt.tx.monitored = tx_pkt_valid & st.mirr[pic_pkg::MIRR_TX_BIT];
    nxt.tx.fwd_normal = tx_pkt_valid;
    if (reset) begin
      nxt = '0;
      nxt.wr_done = pic_pkg::DONE_RST;
      nxt.rd_done = pic_pkg::DONE_RST;
      nxt.mirr = pic_pkg::MIRR_RST;
      nxt.prio_sel = pic_pkg::PRIO_RST;
      nxt.defpri = pic_pkg::DEFPRI_RST;
    end
  end

  always_ff @(posedge clk_sys) begin
    st <= nxt;
  end

  // ==========================================
  // outputs
  assign reg_rdata = st.rd_data;
  assign rx_out = st.rx;
  assign tx_out = st.tx;
  assign sniff_tx_en = st.mirr[pic_pkg::MIRR_SNIF_BIT];

  // ==========================================
  // checks
  logic [127:0] keep_mask;
  genvar gb;
  generate
    for (gb = 0; gb < 16; gb++) begin : g_keep
      assign keep_mask[gb*8 +: 8] = {8{~eng_be[15-gb]}};
    end
  endgenerate

  property p_wr_flag;
    @(posedge clk_sys) disable iff (reset)
    (eng_start && st.dir) |=> !st.wr_done [*4] ##1 st.wr_done;
  endproperty
  a_wr_flag: assert property (p_wr_flag)
    else $error("write flag timing wrong");

  property p_rd_flag;
    @(posedge clk_sys) disable iff (reset)
    (eng_start && !st.dir) |=> !st.rd_done [*4] ##1 st.rd_done;
  endproperty
  a_rd_flag: assert property (p_rd_flag)
    else $error("read flag timing wrong");

  property p_keep_bytes;
    @(posedge clk_sys) disable iff (reset)
    (eng_done && !eng_dir && !reg_wr) |=>
      ((st.win & $past(keep_mask)) == ($past(st.win) & $past(keep_mask)));
  endproperty
  a_keep_bytes: assert property (p_keep_bytes)
    else $error("unselected entry byte changed");

  property p_rx_sniff;
    @(posedge clk_sys) disable iff (reset)
    rx_pkt_valid |=> (rx_out.monitored == $past(st.mirr[pic_pkg::MIRR_RX_BIT]));
  endproperty
  a_rx_sniff: assert property (p_rx_sniff)
    else $error("receive monitor mark wrong");

  property p_tx_sniff;
    @(posedge clk_sys) disable iff (reset)
    tx_pkt_valid |=> (tx_out.monitored == $past(st.mirr[pic_pkg::MIRR_TX_BIT]));
  endproperty
  a_tx_sniff: assert property (p_tx_sniff)
    else $error("transmit monitor mark wrong");

  property p_sniffer;
    @(posedge clk_sys) disable iff (reset)
    (reg_wr && reg_addr == pic_pkg::MIRR_OFF) |=>
      (sniff_tx_en == $past(reg_wdata[pic_pkg::MIRR_SNIF_BIT]));
  endproperty
  a_sniffer: assert property (p_sniffer)
    else $error("sniffer enable wrong");

  property p_default_prio;
    @(posedge clk_sys) disable iff (reset)
    (rx_pkt_valid && ((rx_cls.hit & st.prio_sel[4:0]) == 5'h00)) |=>
      (rx_out.prio == $past(st.defpri));
  endproperty
  a_default_prio: assert property (p_default_prio)
    else $error("default priority not applied");

  property p_fwd_normal;
    @(posedge clk_sys) disable iff (reset)
    (rx_pkt_valid && st.mirr[pic_pkg::MIRR_RX_BIT]) |=>
      (rx_out.fwd_normal && rx_out.monitored);
  endproperty
  a_fwd_normal: assert property (p_fwd_normal)
    else $error("monitored packet not forwarded");

  property p_reserved_zero;
    @(posedge clk_sys) disable iff (reset)
    (reg_rd && reg_addr == pic_pkg::MIRR_OFF) |=> ((reg_rdata & 8'h9d) == 8'h00);
  endproperty
  a_reserved_zero: assert property (p_reserved_zero)
    else $error("reserved bits read nonzero");
endmodule
`default_nettype wire
